/* File: design/lookahead_pkg.sv */
// Shared constants and carriers for the instruction lookahead front end.
// Assumes a 60-bit word machine with 18-bit word addresses.
package lookahead_pkg;
  // Word and parcel geometry
  localparam int WORD_W = 60;
  localparam int PARCEL_W = 15;
  localparam int ADDR_W = 18;
  // Buffer depths of the two variants
  localparam int NARROW_WORDS = 3;
  localparam int DEEP_RANKS = 12;
  localparam int BB_WORDS = 2;
  // Cache geometry: a line is one central storage burst
  localparam int FILL_WORDS = 4;
  localparam int SET_WORDS = 1024;
  localparam int BASE_SETS = 2;
  localparam int MAX_SETS = 4;
  // Program address after reset
  localparam logic [17:0] P_RST = 18'h00000;
  // Opcodes (octal 02..17 written in hex)
  localparam logic [5:0] OP_JUMP = 6'h02;
  localparam logic [5:0] OP_BR_LO = 6'h03;
  localparam logic [5:0] OP_BR_HI = 6'h07;
  localparam logic [5:0] OP_XFER = 6'h08;
  localparam logic [5:0] OP_AND = 6'h09;
  localparam logic [5:0] OP_OR = 6'h0A;
  localparam logic [5:0] OP_XOR = 6'h0B;
  localparam logic [5:0] OP_NOT = 6'h0C;
  localparam logic [5:0] OP_ANDN = 6'h0D;
  localparam logic [5:0] OP_ORN = 6'h0E;
  localparam logic [5:0] OP_XORN = 6'h0F;
  // Operand register load port
  typedef struct packed {
    logic en;
    logic [2:0] sel;
    logic [59:0] data;
  } opr_wr_t;
  // Index register load port
  typedef struct packed {
    logic en;
    logic [2:0] sel;
    logic [17:0] data;
  } idx_wr_t;
  // Issued instruction: 30 bits, short ones in the upper half
  typedef struct packed {
    logic len30;
    logic [17:0] addr;
    logic [29:0] bits;
  } instr_t;
  // Central storage read request
  typedef struct packed {
    logic valid;
    logic [17:0] addr;
  } mem_rd_t;
endpackage

/* File: design/instr_cache.sv */
// Instruction cache: SETS ways of 1024 words, four-word lines.
// Assumes central storage answers a read with four words in order.
`timescale 1ns/100ps
module instr_cache #(
  parameter int SETS = lookahead_pkg::BASE_SETS
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic req_valid,
  input wire logic [17:0] req_addr,
  output logic req_ready,
  output logic resp_valid_ff,
  output logic [59:0] resp_data_ff,
  output lookahead_pkg::mem_rd_t mem_rd_ff,
  input wire logic mem_rd_valid,
  input wire logic [59:0] mem_rd_data
);
  localparam int LINES = lookahead_pkg::SET_WORDS / lookahead_pkg::FILL_WORDS;
  typedef enum logic [1:0] {C_IDLE, C_LOOK, C_FILL} cst_t;

  // Storage arrays, no reset needed; line valid bits are reset
  logic [59:0] data_mem [SETS*lookahead_pkg::SET_WORDS];
  logic [7:0] tag_mem [SETS*LINES];
  logic [SETS*LINES-1:0] vld_ff, nxt_vld;
  cst_t st_ff, nxt_st;
  logic [17:0] addr_ff, nxt_addr;
  logic [1:0] cnt_ff, nxt_cnt, vic_ff, nxt_vic, hit_way;
  logic hit, nxt_resp_v;
  logic [59:0] nxt_resp_d;
  lookahead_pkg::mem_rd_t nxt_mem;

  ////////////////////////////////////////////////////////////////////
  // Tag compare over all ways
  always_comb begin
    hit = 1'b0;
    hit_way = 2'h0;
    for (int w = 0; w < SETS; w++) begin
      if (vld_ff[w*LINES + int'(addr_ff[9:2])] &&
          tag_mem[w*LINES + int'(addr_ff[9:2])] == addr_ff[17:10]) begin
        hit = 1'b1;
        hit_way = 2'(w);
      end
    end
  end

  assign req_ready = (st_ff == C_IDLE);

  ////////////////////////////////////////////////////////////////////
  // Lookup and line fill sequencer
  always_comb begin
    nxt_st = st_ff;
    nxt_addr = addr_ff;
    nxt_cnt = cnt_ff;
    nxt_vic = vic_ff;
    nxt_vld = vld_ff;
    nxt_resp_v = 1'b0;
    nxt_resp_d = resp_data_ff;
    nxt_mem = '{valid: 1'b0, addr: mem_rd_ff.addr};
    unique case (st_ff)
      C_IDLE: begin
        if (req_valid) begin
          nxt_addr = req_addr;
          nxt_st = C_LOOK;
        end
      end
      C_LOOK: begin
        if (hit) begin
          // Hit answers one cycle after lookup
          nxt_resp_v = 1'b1;
          nxt_resp_d = data_mem[int'({hit_way, addr_ff[9:0]})];
          nxt_st = C_IDLE;
        end else begin
          // Miss: burst the aligned line from central storage
          nxt_mem = '{valid: 1'b1, addr: {addr_ff[17:2], 2'h0}};
          nxt_cnt = 2'h0;
          nxt_vld[int'(vic_ff)*LINES + int'(addr_ff[9:2])] = 1'b0;
          nxt_st = C_FILL;
        end
      end
      C_FILL: begin
        if (mem_rd_valid) begin
          nxt_cnt = 2'(cnt_ff + 2'h1);
          if (cnt_ff == 2'(lookahead_pkg::FILL_WORDS - 1)) begin
            nxt_vld[int'(vic_ff)*LINES + int'(addr_ff[9:2])] = 1'b1;
            // Round-robin victim keeps the logic small
            nxt_vic = (vic_ff == 2'(SETS - 1)) ? 2'h0 : 2'(vic_ff + 2'h1);
            nxt_st = C_LOOK;
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      st_ff <= C_IDLE;
      addr_ff <= 18'h00000;
      cnt_ff <= 2'h0;
      vic_ff <= 2'h0;
      vld_ff <= '0;
      resp_valid_ff <= 1'b0;
      resp_data_ff <= 60'h0;
      mem_rd_ff <= '0;
    end else begin
      st_ff <= nxt_st;
      addr_ff <= nxt_addr;
      cnt_ff <= nxt_cnt;
      vic_ff <= nxt_vic;
      vld_ff <= nxt_vld;
      resp_valid_ff <= nxt_resp_v;
      resp_data_ff <= nxt_resp_d;
      mem_rd_ff <= nxt_mem;
    end
  end

  // Array writes during fill; 2048 or 4096 words in all
  always_ff @(posedge clk_sys) begin
    if (st_ff == C_FILL && mem_rd_valid) begin
      data_mem[int'({vic_ff, addr_ff[9:2], cnt_ff})] <= mem_rd_data;
      tag_mem[int'(vic_ff)*LINES + int'(addr_ff[9:2])] <= addr_ff[17:10];
    end
  end

  ////////////////////////////////////////////////////////////////////
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  AST_FILL_FOUR: assert property (
    (st_ff == C_LOOK && !hit) |=> (st_ff == C_FILL) [*4])
    else $error("line fill shorter than four words");
  COV_FILL: cover property (st_ff == C_FILL && mem_rd_valid && cnt_ff == 2'h3);
endmodule

/* File: design/instruction_lookahead_fetch.sv */
// Instruction lookahead front end with Boolean execute group.
// Assumes central storage bursts four words per read request and an
// execution stage that resolves each issued jump with one pulse.
`timescale 1ns/100ps
module instruction_lookahead_fetch #(
  parameter bit DEEP = 1'b0,
  parameter int SETS = lookahead_pkg::BASE_SETS
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  output lookahead_pkg::mem_rd_t mem_rd_ff,
  input wire logic mem_rd_valid,
  input wire logic [59:0] mem_rd_data,
  input wire logic exec_ready,
  output logic instr_valid_ff,
  output lookahead_pkg::instr_t instr_ff,
  input wire logic br_resolve,
  input wire logic br_taken,
  output logic branch_pending_ff,
  output logic [17:0] prog_addr_ff,
  input wire lookahead_pkg::opr_wr_t opr_wr,
  input wire logic [2:0] opr_rd_sel,
  output logic [59:0] opr_rd_data_ff,
  input wire lookahead_pkg::idx_wr_t idx_wr
);
  localparam int QD = DEEP ? lookahead_pkg::DEEP_RANKS
                           : lookahead_pkg::NARROW_WORDS;

  // Queue ranks, head parcel pointer and head word address
  logic [59:0] q_ff [QD], nxt_q [QD];
  logic [3:0] q_cnt_ff, nxt_cnt;
  logic [1:0] pp_ff, nxt_pp;
  logic [17:0] head_ff, nxt_head, nxt_pa, alt_ff, nxt_alt;
  // One outstanding cache read; drop marks a stale answer
  logic infl_ff, nxt_infl, inbb_ff, nxt_inbb, drop_ff, nxt_drop;
  logic nxt_pend, nxt_iv;
  lookahead_pkg::instr_t nxt_instr;
  // Branch buffer of the narrow variant
  logic [59:0] bb_ff [2], nxt_bb [2];
  logic [1:0] bbc_ff, nxt_bbc, bbr_ff, nxt_bbr;
  logic [17:0] bbase_ff, nxt_bbase;
  // Operand and index registers
  logic [59:0] x_ff [8], nxt_x [8];
  logic [17:0] idx_ff [8], nxt_idx [8];
  // Decode of the head parcel
  logic [14:0] cur, nxp;
  logic [5:0] op;
  logic [17:0] kfield, br_tgt;
  logic [59:0] xj, xk, bool_res;
  logic long_op, last, is_br, is_bool, iss, kill;
  // Cache side
  logic c_req, c_ready, c_resp_v;
  logic [17:0] c_addr;
  logic [59:0] c_resp_d;

  // Parcel 0 is the high-order 15 bits
  function automatic logic [14:0] parcel(logic [59:0] w, logic [1:0] n);
    return w[15*(3 - int'(n)) +: 15];
  endfunction

  // 30-bit forms: jumps and the K-constant increments
  function automatic logic is_long(logic [5:0] o);
    return (o >= 6'h01 && o <= 6'h07) || (o >= 6'h28 && o <= 6'h2A) ||
           (o >= 6'h30 && o <= 6'h32) || (o >= 6'h38 && o <= 6'h3A);
  endfunction

  instr_cache #(.SETS(SETS)) u_cache (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .req_valid(c_req),
    .req_addr(c_addr),
    .req_ready(c_ready),
    .resp_valid_ff(c_resp_v),
    .resp_data_ff(c_resp_d),
    .mem_rd_ff(mem_rd_ff),
    .mem_rd_valid(mem_rd_valid),
    .mem_rd_data(mem_rd_data)
  );

  ////////////////////////////////////////////////////////////////////
  // Decode and Boolean result of the head instruction
  always_comb begin
    cur = parcel(q_ff[0], pp_ff);
    // A long form never starts in parcel 3; if it does, low half is zero
    nxp = (pp_ff == 2'h3) ? 15'h0 : parcel(q_ff[0], 2'(pp_ff + 2'h1));
    op = cur[14:9];
    long_op = is_long(op);
    last = long_op ? (pp_ff >= 2'h2) : (pp_ff == 2'h3);
    kfield = {cur[2:0], nxp};
    is_br = (op == lookahead_pkg::OP_JUMP) ||
            (op >= lookahead_pkg::OP_BR_LO && op <= lookahead_pkg::OP_BR_HI);
    // Index zero is held at zero, so a jump on it goes to K
    br_tgt = (op == lookahead_pkg::OP_JUMP) ?
             18'(idx_ff[cur[8:6]] + kfield) : kfield;
    is_bool = (op >= lookahead_pkg::OP_XFER && op <= lookahead_pkg::OP_XORN);
    xj = x_ff[cur[5:3]];
    xk = x_ff[cur[2:0]];
    case (op)
      lookahead_pkg::OP_XFER: bool_res = xj;
      lookahead_pkg::OP_AND: bool_res = xj & xk;
      lookahead_pkg::OP_OR: bool_res = xj | xk;
      lookahead_pkg::OP_XOR: bool_res = xj ^ xk;
      lookahead_pkg::OP_NOT: bool_res = ~xk;
      lookahead_pkg::OP_ANDN: bool_res = xj & ~xk;
      lookahead_pkg::OP_ORN: bool_res = xj | ~xk;
      lookahead_pkg::OP_XORN: bool_res = xj ^ ~xk;
      default: bool_res = 60'h0;
    endcase
    // Issue stalls while a jump waits for its outcome
    iss = (q_cnt_ff != 4'h0) && !branch_pending_ff &&
          (!instr_valid_ff || exec_ready);
  end

  ////////////////////////////////////////////////////////////////////
  // Next state: answer push, issue and pop, resolve, then new fetch.
  // The order matters: later steps override earlier ones.
  always_comb begin
    nxt_q = q_ff;
    nxt_cnt = q_cnt_ff;
    nxt_pp = pp_ff;
    nxt_head = head_ff;
    nxt_pa = prog_addr_ff;
    nxt_alt = alt_ff;
    nxt_infl = infl_ff;
    nxt_inbb = inbb_ff;
    nxt_drop = drop_ff;
    nxt_pend = branch_pending_ff;
    nxt_bb = bb_ff;
    nxt_bbc = bbc_ff;
    nxt_bbr = bbr_ff;
    nxt_bbase = bbase_ff;
    nxt_x = x_ff;
    nxt_idx = idx_ff;
    nxt_iv = instr_valid_ff;
    nxt_instr = instr_ff;
    kill = 1'b0;
    c_req = 1'b0;
    c_addr = prog_addr_ff;
    // Cache answer lands in the queue or the branch buffer
    if (c_resp_v) begin
      nxt_infl = 1'b0;
      if (drop_ff) begin
        nxt_drop = 1'b0;
      end else if (inbb_ff) begin
        nxt_bb[bbc_ff[0]] = c_resp_d;
        nxt_bbc = 2'(bbc_ff + 2'h1);
      end else if (int'(q_cnt_ff) < QD) begin
        nxt_q[int'(q_cnt_ff)] = c_resp_d;
        nxt_cnt = 4'(q_cnt_ff + 4'h1);
      end
    end
    if (exec_ready) begin
      nxt_iv = 1'b0;
    end
    // Issue one parcel or parcel pair
    if (iss) begin
      nxt_iv = 1'b1;
      nxt_instr = '{len30: long_op, addr: head_ff, bits: {cur, long_op ? nxp
                   : 15'h0}};
      if (opr_wr.en) begin
        nxt_x[opr_wr.sel] = opr_wr.data;
      end
      if (is_bool) begin
        nxt_x[cur[8:6]] = bool_res;
      end
      // A jump ends its word; the rest of the word is skipped
      if (last || is_br) begin
        for (int r = 0; r < QD - 1; r++) begin
          nxt_q[r] = nxt_q[r+1];
        end
        nxt_cnt = 4'(nxt_cnt - 4'h1);
        nxt_pp = 2'h0;
        nxt_head = 18'(head_ff + 18'h1);
      end else begin
        nxt_pp = 2'(pp_ff + (long_op ? 2'h2 : 2'h1));
      end
      if (is_br) begin
        nxt_pend = 1'b1;
        nxt_alt = 18'(head_ff + 18'h1);
        if (DEEP) begin
          // Predict taken: drop ranks, fetch at the target
          nxt_cnt = 4'h0;
          nxt_pa = br_tgt;
          nxt_head = br_tgt;
          kill = 1'b1;
        end else begin
          nxt_bbase = br_tgt;
          nxt_bbc = 2'h0;
          nxt_bbr = 2'h0;
        end
      end
    end else if (opr_wr.en) begin
      nxt_x[opr_wr.sel] = opr_wr.data;
    end
    // Index zero never takes a write
    if (idx_wr.en && idx_wr.sel != 3'h0) begin
      nxt_idx[idx_wr.sel] = idx_wr.data;
    end
    // Outcome of the waiting jump
    if (br_resolve && branch_pending_ff) begin
      nxt_pend = 1'b0;
      if (!DEEP && br_taken) begin
        // Buffer words become the queue; refill after them
        for (int r = 0; r < QD; r++) begin
          nxt_q[r] = (r < 2) ? nxt_bb[r[0]] : q_ff[r];
        end
        nxt_cnt = 4'(nxt_bbc);
        nxt_pp = 2'h0;
        nxt_head = bbase_ff;
        nxt_pa = 18'(bbase_ff + 18'(nxt_bbc));
        nxt_bbc = 2'h0;
        kill = 1'b1;
      end else if (!DEEP) begin
        nxt_bbc = 2'h0;
        kill = inbb_ff;
      end else if (!br_taken) begin
        nxt_cnt = 4'h0;
        nxt_pp = 2'h0;
        nxt_pa = alt_ff;
        nxt_head = alt_ff;
        kill = 1'b1;
      end
    end
    // A read still in flight after a redirect is thrown away
    if (kill && infl_ff && !c_resp_v) begin
      nxt_drop = 1'b1;
    end
    // New cache read; buffer words come before sequential ones
    if (c_ready && !infl_ff && !kill) begin
      if (!DEEP && nxt_pend && nxt_bbr < 2'(lookahead_pkg::BB_WORDS)) begin
        c_req = 1'b1;
        c_addr = 18'(nxt_bbase + 18'(nxt_bbr));
        nxt_bbr = 2'(nxt_bbr + 2'h1);
        nxt_inbb = 1'b1;
        nxt_infl = 1'b1;
      end else if (int'(q_cnt_ff) < QD && !(iss && is_br)) begin
        c_req = 1'b1;
        c_addr = prog_addr_ff;
        nxt_pa = 18'(prog_addr_ff + 18'h1);
        nxt_inbb = 1'b0;
        nxt_infl = 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Register stage for all of the above
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      for (int r = 0; r < QD; r++) q_ff[r] <= 60'h0;
      for (int r = 0; r < 8; r++) begin
        x_ff[r] <= 60'h0;
        idx_ff[r] <= 18'h00000;
      end
      bb_ff[0] <= 60'h0;
      bb_ff[1] <= 60'h0;
      q_cnt_ff <= 4'h0;
      pp_ff <= 2'h0;
      head_ff <= lookahead_pkg::P_RST;
      prog_addr_ff <= lookahead_pkg::P_RST;
      alt_ff <= lookahead_pkg::P_RST;
      bbase_ff <= lookahead_pkg::P_RST;
      bbc_ff <= 2'h0;
      bbr_ff <= 2'h0;
      infl_ff <= 1'b0;
      inbb_ff <= 1'b0;
      drop_ff <= 1'b0;
      branch_pending_ff <= 1'b0;
      instr_valid_ff <= 1'b0;
      instr_ff <= '0;
      opr_rd_data_ff <= 60'h0;
    end else begin
      q_ff <= nxt_q;
      x_ff <= nxt_x;
      idx_ff <= nxt_idx;
      bb_ff <= nxt_bb;
      q_cnt_ff <= nxt_cnt;
      pp_ff <= nxt_pp;
      head_ff <= nxt_head;
      prog_addr_ff <= nxt_pa;
      alt_ff <= nxt_alt;
      bbase_ff <= nxt_bbase;
      bbc_ff <= nxt_bbc;
      bbr_ff <= nxt_bbr;
      infl_ff <= nxt_infl;
      inbb_ff <= nxt_inbb;
      drop_ff <= nxt_drop;
      branch_pending_ff <= nxt_pend;
      instr_valid_ff <= nxt_iv;
      instr_ff <= nxt_instr;
      opr_rd_data_ff <= x_ff[opr_rd_sel];
    end
  end

  ////////////////////////////////////////////////////////////////////
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  AST_NARROW_DEPTH: assert property (!DEEP |-> q_cnt_ff <= 4'h3)
    else $error("narrow queue above three words");
  AST_DEEP_DEPTH: assert property (DEEP |-> q_cnt_ff <= 4'hC)
    else $error("deep ranks above twelve");
  AST_BB_LIMIT: assert property (bbc_ff <= 2'h2)
    else $error("branch buffer above two words");
  AST_NT_PURGE: assert property (
    (!DEEP && br_resolve && branch_pending_ff && !br_taken)
      |=> bbc_ff == 2'h0 && !branch_pending_ff)
    else $error("branch buffer kept after untaken branch");
  AST_TAKEN_REFILL: assert property (
    (!DEEP && br_resolve && branch_pending_ff && br_taken)
      |=> head_ff == $past(bbase_ff) && q_cnt_ff <= 4'h2)
    else $error("taken branch did not restart at buffer");
  AST_PREDICT: assert property (
    (DEEP && iss && is_br) |=> prog_addr_ff == $past(br_tgt) &&
      q_cnt_ff == 4'h0 && branch_pending_ff)
    else $error("deep variant did not fetch the target");
  AST_DEEP_FLUSH: assert property (
    (DEEP && br_resolve && branch_pending_ff && !br_taken)
      |=> q_cnt_ff == 4'h0 && prog_addr_ff == $past(alt_ff))
    else $error("untaken branch did not refetch after it");
  AST_PARCEL: assert property (
    iss |=> instr_valid_ff && instr_ff.bits[29:15] == $past(cur))
    else $error("issued parcel mismatch");
  AST_IDX0: assert property (idx_ff[0] == 18'h00000)
    else $error("index register zero not zero");
  AST_BOOL_OR: assert property (
    (iss && op == lookahead_pkg::OP_OR) |=>
      x_ff[$past(cur[8:6])] == ($past(xj) | $past(xk)))
    else $error("OR result wrong");
  COV_TAKEN: cover property (br_resolve && branch_pending_ff && br_taken);
  COV_UNTAKEN: cover property (br_resolve && branch_pending_ff && !br_taken);
  COV_LONG: cover property (iss && long_op && pp_ff == 2'h2);
endmodule

/* File: verification/storage_model.sv */
// Central storage stand-in answering four-word read bursts.
// Assumes one outstanding request; bench preloads the words array.
`timescale 1ns/100ps
module storage_model (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire lookahead_pkg::mem_rd_t mem_rd_ff,
  output logic mem_rd_valid,
  output logic [59:0] mem_rd_data,
  output logic overlap_seen
);
  ////////////////////////////////////////////////////////////////////////
  // Small program store, address wraps at 64 words
  logic [59:0] words [0:63];
  logic [17:0] base; // Line address of the burst
  logic [2:0] left; // Words still owed
  logic [2:0] sent; // Words already returned
  logic [1:0] wait_cnt; // Latency and gap counter

  ////////////////////////////////////////////////////////////////////////
  // Burst engine: slow first word, gaps on odd lines to stress the queue
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      base <= 18'h00000;
      left <= 3'h0;
      sent <= 3'h0;
      wait_cnt <= 2'h0;
      mem_rd_valid <= 1'b0;
      mem_rd_data <= 60'h000000000000000;
      overlap_seen <= 1'b0;
    end else begin
      mem_rd_valid <= 1'b0;
      // Idle data toggles so a stale word is never mistaken for a fresh one
      mem_rd_data <= ~mem_rd_data;
      if (mem_rd_ff.valid) begin
        // A new request while owing words breaks the one-burst order
        if (left != 3'h0) begin
          overlap_seen <= 1'b1;
        end
        base <= mem_rd_ff.addr;
        left <= 3'h4;
        sent <= 3'h0;
        wait_cnt <= 2'h3;
      end else if (wait_cnt != 2'h0) begin
        wait_cnt <= wait_cnt - 2'h1;
      end else if (left != 3'h0) begin
        // Consecutive words in address order
        mem_rd_valid <= 1'b1;
        mem_rd_data <= words[6'(base[5:0] + {3'h0, sent})];
        sent <= sent + 3'h1;
        left <= left - 3'h1;
        wait_cnt <= {1'b0, base[2]};
      end
    end
  end
endmodule

/* File: verification/instruction_lookahead_fetch_bench.sv */
// Self-checking bench: narrow front end judged, deep one run alongside.
// Assumes storage_model on the memory link and the package constants.
`timescale 1ns/100ps
module instruction_lookahead_fetch_bench;
  ////////////////////////////////////////////////////////////////////////
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  lookahead_pkg::mem_rd_t mem_rd_ff;
  logic mem_rd_valid;
  logic [59:0] mem_rd_data;
  logic exec_ready = 1'b0;
  logic instr_valid_ff;
  lookahead_pkg::instr_t instr_ff;
  logic br_resolve = 1'b0;
  logic br_taken = 1'b0;
  logic branch_pending_ff;
  logic [17:0] prog_addr_ff;
  lookahead_pkg::opr_wr_t opr_wr = '0;
  logic [2:0] opr_rd_sel = 3'h0;
  logic [59:0] opr_rd_data_ff;
  lookahead_pkg::idx_wr_t idx_wr = '0;
  logic overlap_seen;
  int bad_count = 0;
  int samples_checked = 0;
  int cycles = 0;
  logic saw_target = 1'b0; // Branch target line was requested
  logic misaligned = 1'b0; // A request was not line aligned
  logic deep_tgt = 1'b0; // Deep variant fetched the first jump target
  logic [59:0] xa = 60'h0F0F12345678ABC;
  logic [59:0] xb = 60'h00FF00FF00FF00F;
  // Boolean program: opcode and destination per parcel, j=2 k=3
  logic [5:0] ops [0:7] = '{6'h08, 6'h0A, 6'h0B, 6'h0C, 6'h0D, 6'h0E,
                            6'h0F, 6'h09};
  logic [2:0] dsts [0:7] = '{3'h1, 3'h4, 3'h5, 3'h6, 3'h7, 3'h1, 3'h4, 3'h6};

  always #5 clk_sys = ~clk_sys;

  instruction_lookahead_fetch uut (.clk_sys(clk_sys), .rst_b(rst_b),
    .mem_rd_ff(mem_rd_ff), .mem_rd_valid(mem_rd_valid),
    .mem_rd_data(mem_rd_data), .exec_ready(exec_ready),
    .instr_valid_ff(instr_valid_ff), .instr_ff(instr_ff),
    .br_resolve(br_resolve), .br_taken(br_taken),
    .branch_pending_ff(branch_pending_ff), .prog_addr_ff(prog_addr_ff),
    .opr_wr(opr_wr), .opr_rd_sel(opr_rd_sel),
    .opr_rd_data_ff(opr_rd_data_ff), .idx_wr(idx_wr));

  storage_model mem (.clk_sys(clk_sys), .rst_b(rst_b),
    .mem_rd_ff(mem_rd_ff), .mem_rd_valid(mem_rd_valid),
    .mem_rd_data(mem_rd_data), .overlap_seen(overlap_seen));

  // Deep variant on the same stimulus; its own assertions guard the ranks
  if (1) begin : deep_side
    lookahead_pkg::mem_rd_t mem_rd_ff;
    logic mem_rd_valid;
    logic [59:0] mem_rd_data;
    instruction_lookahead_fetch #(.DEEP(1'b1)) uut (.clk_sys(clk_sys),
      .rst_b(rst_b), .mem_rd_ff(mem_rd_ff), .mem_rd_valid(mem_rd_valid),
      .mem_rd_data(mem_rd_data), .exec_ready(exec_ready),
      .instr_valid_ff(), .instr_ff(), .br_resolve(br_resolve),
      .br_taken(br_taken), .branch_pending_ff(), .prog_addr_ff(),
      .opr_wr(opr_wr), .opr_rd_sel(opr_rd_sel), .opr_rd_data_ff(),
      .idx_wr(idx_wr));
    storage_model mem (.clk_sys(clk_sys), .rst_b(rst_b),
      .mem_rd_ff(mem_rd_ff), .mem_rd_valid(mem_rd_valid),
      .mem_rd_data(mem_rd_data), .overlap_seen());
  end

  ////////////////////////////////////////////////////////////////////////
  // Link watcher and hang guard; run needs well under 5000 cycles
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (mem_rd_ff.valid && mem_rd_ff.addr[1:0] != 2'h0) begin
      misaligned <= 1'b1;
    end
    if (mem_rd_ff.valid && mem_rd_ff.addr == 18'h00030) begin
      saw_target <= 1'b1;
    end
    // Line 16 is never reached sequentially, only by predicting the jump
    if (deep_side.mem_rd_ff.valid &&
        deep_side.mem_rd_ff.addr == 18'h00010) begin
      deep_tgt <= 1'b1;
    end
    if (cycles == 20000) begin
      bad_count = bad_count + 1;
      report_and_stop();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [59:0] exp,
                     input logic [59:0] got);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Wait for an issued instruction, judge it, then take it in one cycle
  task automatic take(input logic [17:0] a, input logic [29:0] b,
                      input logic l);
    int n;
    n = 0;
    @(negedge clk_sys);
    while (instr_valid_ff !== 1'b1 && n < 500) begin
      @(negedge clk_sys);
      n++;
    end
    chk("issue address", 60'(a), 60'(instr_ff.addr));
    chk("issue bits", 60'(b), 60'(instr_ff.bits));
    chk("issue length", 60'(l), 60'(instr_ff.len30));
    @(posedge clk_sys) exec_ready <= 1'b1;
    @(posedge clk_sys) exec_ready <= 1'b0;
  endtask

  // Operand read answers one cycle after the select
  task automatic read_x(input logic [2:0] sel, input logic [59:0] exp);
    @(posedge clk_sys) opr_rd_sel <= sel;
    @(posedge clk_sys);
    @(negedge clk_sys);
    chk("operand register", exp, opr_rd_data_ff);
  endtask

  task automatic wait_pending();
    int n;
    n = 0;
    while (branch_pending_ff !== 1'b1 && n < 100) begin
      @(negedge clk_sys);
      n++;
    end
    chk("branch pending", 60'h1, 60'(branch_pending_ff));
  endtask

  // Resolve the jump in flight; pending must fall at the taking edge
  task automatic resolve(input logic t);
    @(posedge clk_sys) begin
      br_resolve <= 1'b1;
      br_taken <= t;
    end
    @(posedge clk_sys) br_resolve <= 1'b0;
    @(negedge clk_sys);
    chk("pending after resolve", 60'h0, 60'(branch_pending_ff));
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Boolean group issued parcel by parcel, results read back
  task automatic t_boolean();
    logic [59:0] exp;
    @(posedge clk_sys) opr_wr <= '{en: 1'b1, sel: 3'h2, data: xa};
    @(posedge clk_sys) opr_wr <= '{en: 1'b1, sel: 3'h3, data: xb};
    @(posedge clk_sys) opr_wr <= '0;
    for (int p = 0; p < 8; p++) begin
      case (ops[p])
        6'h08: exp = xa;
        6'h09: exp = xa & xb;
        6'h0A: exp = xa | xb;
        6'h0B: exp = xa ^ xb;
        6'h0C: exp = ~xb;
        6'h0D: exp = xa & ~xb;
        6'h0E: exp = xa | ~xb;
        default: exp = xa ^ ~xb;
      endcase
      take(18'(p / 4), {ops[p], dsts[p], 6'h13, 15'h0000}, 1'b0);
      read_x(dsts[p], exp);
    end
    $display("boolean test done");
  endtask

  // Jumps: index zero base, taken and untaken conditionals, refill point
  task automatic t_jumps();
    @(posedge clk_sys) idx_wr <= '{en: 1'b1, sel: 3'h0, data: 18'h00005};
    @(posedge clk_sys) idx_wr <= '0;
    take(18'h00002, {12'h080, 18'h00010}, 1'b1);
    wait_pending();
    resolve(1'b1);
    saw_target = 1'b0;
    take(18'h00010, {12'h100, 18'h00030}, 1'b1);
    wait_pending();
    for (int n = 0; n < 200 && saw_target !== 1'b1; n++) @(negedge clk_sys);
    chk("target line fetched", 60'h1, 60'(saw_target));
    resolve(1'b0);
    take(18'h00011, {12'h140, 18'h00030}, 1'b1);
    wait_pending();
    resolve(1'b1);
    take(18'h00030, {15'h23D2, 15'h0000}, 1'b0);
    for (int k = 1; k < 6; k++) begin
      take(18'h00030 + 18'(k / 4), {15'h4000, 15'h0000}, 1'b0);
    end
    take(18'h00031, 30'h28000001, 1'b1);
    take(18'h00032, {15'h4000, 15'h0000}, 1'b0);
    take(18'h00032, {15'h4000, 15'h0000}, 1'b0);
    chk("request aligned", 60'h0, 60'(misaligned));
    chk("deep target fetched", 60'h1, 60'(deep_tgt));
    chk("one burst at a time", 60'h0, 60'(overlap_seen));
    $display("jump test done");
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Program image, reset checks, then the scenarios
  initial begin
    for (int i = 0; i < 64; i++) mem.words[i] = {4{15'h4000}};
    for (int p = 0; p < 8; p++) begin
      mem.words[p / 4][59 - 15 * (p % 4) -: 15] = {ops[p], dsts[p], 6'h13};
    end
    mem.words[2] = {12'h080, 18'h00010, 30'h00000000};
    mem.words[16] = {12'h100, 18'h00030, 30'h00000000};
    mem.words[17] = {12'h140, 18'h00030, 30'h00000000};
    mem.words[48][59:45] = 15'h23D2;
    // Word 49 ends in a 30-bit form starting at parcel 2
    mem.words[49][29:0] = 30'h28000001;
    deep_side.mem.words = mem.words;
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
    chk("address in reset", 60'h0, 60'(prog_addr_ff));
    chk("valid in reset", 60'h0, 60'(instr_valid_ff));
    chk("pending in reset", 60'h0, 60'(branch_pending_ff));
    $display("reset test done");
    @(posedge clk_sys) rst_b <= 1'b1;
    t_boolean();
    t_jumps();
    report_and_stop();
  end
endmodule
